// ### design/analog_watchdog_pkg.sv
/*
 * Constants, register map and field layout of the analog window watchdog.
 * Assumes a single 50 MHz clock and an AHB-Lite master driving the registers.
 */
// Behaviour
// - Arm rise captures current sample as reference; monitoring starts.
// - Gain accepts -10.00 to 10.00 in hundredths; excess saturates.
// - Zero offset accepts -10000 to 10000; writes beyond saturate.
// - Upper margin accepts 0 to 20000, added to reference.
// - Lower margin accepts 0 to 20000, subtracted from reference.
// - Sample selects analog, flag, network, output or block sources.
// - With retention on, state survives power loss; else it is cleared.
// - Decimal places 0..3 are display only, never used in comparison.
// - Each margin may come live from another block chosen by number.
// - Sample and reference are scaled as raw times gain plus offset.
// - Alarm is set while armed and scaled sample is outside the window.
// - Alarm clears when sample is inside the window or arm goes low.
package analog_watchdog_pkg;
    localparam int VAL_W      = 16;
    localparam int ACT_W      = 32;
    localparam int GAIN_W     = 12;
    localparam int N_PHYS     = 8;
    localparam int N_FLAG     = 64;
    localparam int N_NETIN    = 32;
    localparam int N_AOUT     = 8;
    localparam int N_NETOUT   = 16;
    localparam int N_BLK      = 16;
    localparam int N_SRC      = N_PHYS + N_FLAG + N_NETIN + N_AOUT
                                + N_NETOUT + N_BLK;
    localparam int SEL_W      = 8;
    localparam int BLK_W      = 8;

    localparam logic signed [ACT_W-1:0] GAIN_MIN   = -32'sd1000;
    localparam logic signed [ACT_W-1:0] GAIN_MAX   = 32'sd1000;
    localparam logic signed [ACT_W-1:0] GAIN_DIV   = 32'sd100;
    localparam logic signed [ACT_W-1:0] OFFS_MIN   = -32'sd10000;
    localparam logic signed [ACT_W-1:0] OFFS_MAX   = 32'sd10000;
    localparam logic signed [ACT_W-1:0] MARG_MIN   = 32'sd0;
    localparam logic signed [ACT_W-1:0] MARG_MAX   = 32'sd20000;
    localparam logic [1:0]              DEC_MAX    = 2'h3;

    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_GAIN     = 8'h04;
    localparam logic [7:0] A_OFFSET   = 8'h08;
    localparam logic [7:0] A_UPPER    = 8'h0C;
    localparam logic [7:0] A_LOWER    = 8'h10;
    localparam logic [7:0] A_SRC      = 8'h14;
    localparam logic [7:0] A_MBLK     = 8'h18;
    localparam logic [7:0] A_DEC      = 8'h1C;
    localparam logic [7:0] A_STATUS   = 8'h20;
    localparam logic [7:0] A_REF      = 8'h24;
    localparam logic [7:0] A_SAMPLE   = 8'h28;
    localparam logic [7:0] A_INTSTAT  = 8'h2C;
    localparam logic [7:0] A_INTMASK  = 8'h30;

    localparam int CTRL_RETAIN  = 0;
    localparam int CTRL_UPLIVE  = 1;
    localparam int CTRL_LOLIVE  = 2;
    localparam int CTRL_W       = 3;
    localparam int ST_ALARM     = 0;
    localparam int ST_ARMED     = 1;
    localparam int ST_REFVALID  = 2;
    localparam int EV_CAPTURE   = 0;
    localparam int EV_ALARM_ON  = 1;
    localparam int EV_ALARM_OFF = 2;
    localparam int EV_W         = 3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'b0;
endpackage

// ### design/wd_scaler.sv
/*
 * Scales a raw analog value: raw * gain / 100 + offset.
 * Assumes gain and offset already lie in their legal ranges.
 */
`timescale 1ns/1ps
module wd_scaler
    import analog_watchdog_pkg::*;
(
    input  wire logic signed [VAL_W-1:0]  raw,     // raw analog value
    input  wire logic signed [GAIN_W-1:0] gain,    // gain in hundredths
    input  wire logic signed [VAL_W-1:0]  offset,  // zero offset
    output logic signed [ACT_W-1:0]       actual   // scaled value
);
    logic signed [ACT_W-1:0] product;
    logic signed [ACT_W-1:0] quotient;

    // division truncates toward zero, as the scan engine did
    assign product  = ACT_W'(raw) * ACT_W'(gain);
    assign quotient = product / GAIN_DIV;
    assign actual   = quotient + ACT_W'(offset);
endmodule

// ### design/wd_window.sv
/*
 * Window check: flags a sample outside reference-lower .. reference+upper.
 * Assumes margins are non-negative and already saturated.
 */
`timescale 1ns/1ps
module wd_window
    import analog_watchdog_pkg::*;
(
    input  wire logic signed [ACT_W-1:0] sample,   // scaled sample
    input  wire logic signed [ACT_W-1:0] refVal,   // scaled reference
    input  wire logic signed [ACT_W-1:0] upper,    // upper margin
    input  wire logic signed [ACT_W-1:0] lower,    // lower margin
    output logic                         outside   // sample left window
);
    logic signed [ACT_W-1:0] top;
    logic signed [ACT_W-1:0] bottom;

    assign top     = refVal + upper;
    assign bottom  = refVal - lower;
    // edges of the window count as inside
    assign outside = (sample > top) || (sample < bottom);
endmodule

// ### design/analog_window_watchdog.sv
/*
 * Analog window watchdog with AHB-Lite register access and interrupt.
 * Assumes all inputs synchronous to clock; scanStrobe marks one program
 * scan; powerRestore pulses once when supply returns after a loss.
 */
`timescale 1ns/1ps
module analog_window_watchdog
    import analog_watchdog_pkg::*;
(
    input  wire logic                     clock,        // 50 MHz
    input  wire logic                     rst,          // sync, high
    input  wire logic                     hsel,         // slave select
    input  wire logic [31:0]              haddr,        // byte address
    input  wire logic [1:0]               htrans,       // transfer type
    input  wire logic                     hwrite,       // write
    input  wire logic [2:0]               hsize,        // word only
    input  wire logic [31:0]              hwdata,       // write data
    input  wire logic                     hready,       // bus ready
    output logic                          hreadyout,    // slave ready
    output logic [31:0]                   hrdata,       // read data
    output logic                          hresp,        // response
    input  wire logic                     armIn,        // arm level
    input  wire logic                     scanStrobe,   // scan pulse
    input  wire logic                     powerRestore, // power back
    input  wire logic [N_PHYS*VAL_W-1:0]  physicalAnalogInput,
    input  wire logic [N_FLAG*VAL_W-1:0]  analogFlag,
    input  wire logic [N_NETIN*VAL_W-1:0] networkAnalogInput,
    input  wire logic [N_AOUT*VAL_W-1:0]  analogOutputValue,
    input  wire logic [N_NETOUT*VAL_W-1:0] networkAnalogOutput,
    input  wire logic [N_BLK*VAL_W-1:0]   blockResult,  // other blocks
    output logic                          alarm,        // window alarm
    output logic                          irq           // interrupt
);
    import analog_watchdog_pkg::*;

    localparam int ALL_W = N_SRC * VAL_W;

    logic [CTRL_W-1:0]       ctrl;
    logic signed [GAIN_W-1:0] gain;
    logic signed [VAL_W-1:0] offset;
    logic [VAL_W-1:0]        upperMargin;
    logic [VAL_W-1:0]        lowerMargin;
    logic [SEL_W-1:0]        srcSel;
    logic [BLK_W-1:0]        upperBlk;
    logic [BLK_W-1:0]        lowerBlk;
    logic [1:0]              decimals;
    logic [EV_W-1:0]         intStat;
    logic [EV_W-1:0]         intMask;
    logic signed [VAL_W-1:0] refRaw;
    logic                    refValid;
    logic                    armPrev;

    logic                    dpWrite;
    logic [7:0]              dpAddr;

    // every selectable source packed into one table
    logic [ALL_W-1:0]        allSrc;
    logic [VAL_W-1:0]        srcArr [N_SRC];
    logic signed [VAL_W-1:0] sampleRaw;
    logic signed [ACT_W-1:0] sampleAct;
    logic signed [ACT_W-1:0] refAct;
    logic signed [ACT_W-1:0] upperEff;
    logic signed [ACT_W-1:0] lowerEff;
    logic                    outside;

    assign allSrc = {blockResult, networkAnalogOutput, analogOutputValue,
                     networkAnalogInput, analogFlag, physicalAnalogInput};

    genvar gi;
    generate
        for (gi = 0; gi < N_SRC; gi++) begin : g_src
            assign srcArr[gi] = allSrc[gi*VAL_W +: VAL_W];
        end
    endgenerate

    function automatic logic signed [ACT_W-1:0] sat(
        input logic signed [ACT_W-1:0] v,
        input logic signed [ACT_W-1:0] lo,
        input logic signed [ACT_W-1:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction

    // out-of-range source numbers read as zero rather than wrapping
    wire srcOk = (32'(srcSel) < N_SRC);
    assign sampleRaw = srcOk ? srcArr[srcSel] : '0;

    wire upBlkOk = (32'(upperBlk) < N_BLK);
    wire loBlkOk = (32'(lowerBlk) < N_BLK);
    wire signed [ACT_W-1:0] upLive = upBlkOk
        ? ACT_W'($signed(srcArr[N_SRC-N_BLK+32'(upperBlk)])) : '0;
    wire signed [ACT_W-1:0] loLive = loBlkOk
        ? ACT_W'($signed(srcArr[N_SRC-N_BLK+32'(lowerBlk)])) : '0;

    // live margins are held to the same range as constant ones
    assign upperEff = ctrl[CTRL_UPLIVE]
        ? sat(upLive, MARG_MIN, MARG_MAX)
        : ACT_W'(upperMargin);
    assign lowerEff = ctrl[CTRL_LOLIVE]
        ? sat(loLive, MARG_MIN, MARG_MAX)
        : ACT_W'(lowerMargin);

    wd_scaler u_sampleScale (
        .raw    (sampleRaw),
        .gain   (gain),
        .offset (offset),
        .actual (sampleAct)
    );

    // reference kept raw and rescaled, so gain changes reach both sides
    wd_scaler u_refScale (
        .raw    (refRaw),
        .gain   (gain),
        .offset (offset),
        .actual (refAct)
    );

    wd_window u_window (
        .sample  (sampleAct),
        .refVal  (refAct),
        .upper   (upperEff),
        .lower   (lowerEff),
        .outside (outside)
    );

    // scan evaluation
    wire armRise   = scanStrobe && armIn && !armPrev;
    // at capture refRaw still holds the old reference, so the capture scan is kept from alarming
    wire alarmNext = armIn && refValid && outside && !armRise;
    wire lossClear = powerRestore && !ctrl[CTRL_RETAIN];

    // bus decode
    wire        apValid = hsel && hready && htrans[1];
    wire        wrEn    = dpWrite;
    wire [31:0] wd      = hwdata;
    wire signed [ACT_W-1:0] wdS = $signed(wd);

    wire [EV_W-1:0] events = {
        scanStrobe && alarm && !alarmNext,
        scanStrobe && !alarm && alarmNext,
        armRise};
    wire [EV_W-1:0] intClr = (wrEn && dpAddr == A_INTSTAT)
                             ? wd[EV_W-1:0] : '0;
    wire [EV_W-1:0] next_intStat = (intStat & ~intClr) | events;
    // irq must follow a mask write in the cycle the mask itself changes
    wire [EV_W-1:0] next_intMask = (wrEn && dpAddr == A_INTMASK)
                                   ? wd[EV_W-1:0] : intMask;

    logic [31:0] rdMux;
    always_comb begin
        rdMux = '0;
        case (haddr[7:0])
            A_CTRL:    rdMux = 32'(ctrl);
            A_GAIN:    rdMux = 32'($signed(gain));
            A_OFFSET:  rdMux = 32'($signed(offset));
            A_UPPER:   rdMux = 32'(upperMargin);
            A_LOWER:   rdMux = 32'(lowerMargin);
            A_SRC:     rdMux = 32'(srcSel);
            A_MBLK:    rdMux = {16'h0000, lowerBlk, upperBlk};
            A_DEC:     rdMux = 32'(decimals);
            A_STATUS:  rdMux = {29'h0, refValid, armIn && refValid, alarm};
            A_REF:     rdMux = refAct;
            A_SAMPLE:  rdMux = sampleAct;
            A_INTSTAT: rdMux = 32'(intStat);
            A_INTMASK: rdMux = 32'(intMask);
            default:   rdMux = '0;
        endcase
    end
    wire hitHigh = |haddr[31:8];

    always_ff @(posedge clock) begin
        if (rst) begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
            hrdata    <= '0;
            dpWrite   <= 1'b0;
            dpAddr    <= '0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
            dpWrite   <= apValid && hwrite && !hitHigh;
            dpAddr    <= haddr[7:0];
            if (apValid && !hwrite) begin
                hrdata <= hitHigh ? '0 : rdMux;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl        <= '0;
            gain        <= '0;
            offset      <= '0;
            upperMargin <= '0;
            lowerMargin <= '0;
            srcSel      <= '0;
            upperBlk    <= '0;
            lowerBlk    <= '0;
            decimals    <= '0;
            intMask     <= '0;
        end else if (wrEn) begin
            case (dpAddr)
                A_CTRL:    ctrl <= wd[CTRL_W-1:0];
                A_GAIN:    gain <= GAIN_W'(sat(wdS, GAIN_MIN,
                                                GAIN_MAX));
                A_OFFSET:  offset <= VAL_W'(sat(wdS, OFFS_MIN,
                                                OFFS_MAX));
                A_UPPER:   upperMargin <= VAL_W'(sat(wdS, MARG_MIN,
                                                MARG_MAX));
                A_LOWER:   lowerMargin <= VAL_W'(sat(wdS, MARG_MIN,
                                                MARG_MAX));
                A_SRC:     srcSel <= wd[SEL_W-1:0];
                A_MBLK: begin
                    upperBlk <= wd[BLK_W-1:0];
                    lowerBlk <= wd[2*BLK_W-1:BLK_W];
                end
                // display only; never reaches the window check
                A_DEC:     decimals <= (wd[1:0] > DEC_MAX)
                                       ? DEC_MAX : wd[1:0];
                A_INTMASK: intMask <= wd[EV_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            refRaw   <= '0;
            refValid <= 1'b0;
            armPrev  <= 1'b0;
            alarm    <= 1'b0;
        end else if (lossClear) begin
            refRaw   <= '0;
            refValid <= 1'b0;
            armPrev  <= 1'b0;
            alarm    <= 1'b0;
        end else if (scanStrobe) begin
            armPrev <= armIn;
            if (armRise) begin
                refRaw   <= sampleRaw;
                refValid <= 1'b1;
            end
            alarm <= alarmNext;
        end
    end

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge clock) begin
        if (rst) begin
            intStat <= '0;
            irq     <= 1'b0;
        end else begin
            intStat <= next_intStat;
            irq     <= |(next_intStat & next_intMask);
        end
    end
endmodule

// ### dv/analog_sources_model.sv
/*
 * Far-side model: the analog sources that feed the watchdog's sample mux.
 * Assumes the bench loads one 16-bit value per cycle through setEn.
 */
`timescale 1ns/1ps
module analog_sources_model
    import analog_watchdog_pkg::*;
(
    input  wire logic                      clock,  // bench clock
    input  wire logic                      rst,    // clears all sources
    input  wire logic                      setEn,  // load strobe
    input  wire logic [7:0]                setIdx, // source index 0..143
    input  wire logic [15:0]               setVal, // value to load
    output logic [N_PHYS*VAL_W-1:0]        physicalAnalogInput,   // ai
    output logic [N_FLAG*VAL_W-1:0]        analogFlag,            // flags
    output logic [N_NETIN*VAL_W-1:0]       networkAnalogInput,    // net in
    output logic [N_AOUT*VAL_W-1:0]        analogOutputValue,     // aq
    output logic [N_NETOUT*VAL_W-1:0]      networkAnalogOutput,   // net out
    output logic [N_BLK*VAL_W-1:0]         blockResult            // blocks
);
    logic [15:0] mem [0:143];

    // one flat table keeps the source numbering in one place
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 144; i++) mem[i] <= 16'h0000;
        end else if (setEn) begin
            mem[setIdx] <= setVal;
        end
    end

    for (genvar i = 0; i < 144; i++) begin : g_map
        if (i < 8) begin : g_a
            assign physicalAnalogInput[16*i+:16] = mem[i];
        end else if (i < 72) begin : g_f
            assign analogFlag[16*(i-8)+:16] = mem[i];
        end else if (i < 104) begin : g_n
            assign networkAnalogInput[16*(i-72)+:16] = mem[i];
        end else if (i < 112) begin : g_o
            assign analogOutputValue[16*(i-104)+:16] = mem[i];
        end else if (i < 128) begin : g_q
            assign networkAnalogOutput[16*(i-112)+:16] = mem[i];
        end else begin : g_b
            assign blockResult[16*(i-128)+:16] = mem[i];
        end
    end
endmodule

// ### dv/analog_window_watchdog_checker.sv
/*
 * Concurrent checks on the watchdog's ports.
 * Assumes one clock domain; bound onto every watchdog instance.
 */
`timescale 1ns/1ps
module analog_window_watchdog_checker (
    input  wire logic        clock,        // clock
    input  wire logic        rst,          // sync reset
    input  wire logic        hsel,         // select
    input  wire logic [31:0] haddr,        // address
    input  wire logic [1:0]  htrans,       // transfer type
    input  wire logic        hwrite,       // write
    input  wire logic        hready,       // bus ready
    input  wire logic        hreadyout,    // slave ready
    input  wire logic [31:0] hrdata,       // read data
    input  wire logic        hresp,        // response
    input  wire logic        armIn,        // arm level
    input  wire logic        scanStrobe,   // scan pulse
    input  wire logic        powerRestore, // power back
    input  wire logic        alarm,        // alarm
    input  wire logic        irq           // interrupt
);
    logic armPrevH;
    wire  rdReq = hsel && hready && htrans[1] && !hwrite;
    wire  wrReq = hsel && hready && htrans[1] && hwrite;

    // never cleared by power restore: only ever misses a rise, never invents
    always_ff @(posedge clock) begin
        if (rst) armPrevH <= 1'b0;
        else if (scanStrobe) armPrevH <= armIn;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence armRiseScan;
        scanStrobe && armIn && !armPrevH;
    endsequence
    sequence quietCycle;
        !scanStrobe && !powerRestore;
    endsequence

    ready_always_a: assert property (hreadyout)
        else $error("hreadyout dropped");
    resp_okay_a: assert property (!hresp)
        else $error("hresp not okay");
    capture_quiet_a: assert property (
        armRiseScan |=> !alarm)
        else $error("alarm on capture scan");
    disarm_clear_a: assert property (
        scanStrobe && !armIn |=> !alarm)
        else $error("alarm while disarmed");
    alarm_cause_a: assert property (
        $rose(alarm) |-> $past(scanStrobe) && $past(armIn))
        else $error("alarm rose without armed scan");
    alarm_hold_a: assert property (
        quietCycle |=> $stable(alarm))
        else $error("alarm moved between scans");
    restore_norise_a: assert property (
        powerRestore && !scanStrobe |=> !$rose(alarm))
        else $error("alarm rose on power restore");
    unmapped_zero_a: assert property (
        rdReq && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!rdReq |=> $stable(hrdata))
        else $error("hrdata moved without read");
    // events need a scan; a mask write lands one cycle after its address
    irq_cause_a: assert property (
        $rose(irq) |-> $past(scanStrobe) || $past(wrReq, 2))
        else $error("irq rose without event or mask write");
endmodule

bind analog_window_watchdog analog_window_watchdog_checker u_checker (
    .clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
    .hrdata, .hresp, .armIn, .scanStrobe, .powerRestore, .alarm, .irq);

// ### dv/analog_window_watchdog_tb.sv
/*
 * Self-checking bench: AHB-Lite register tasks, scan and source tasks.
 * Assumes a zero-wait slave; the master still waits on ready.
 */
`timescale 1ns/1ps
module analog_window_watchdog_tb;
    import analog_watchdog_pkg::*;
    logic clock = 0, rst = 1, hsel = 0, hwrite = 0, armIn = 0;
    logic scanStrobe = 0, powerRestore = 0, setEn = 0, hreadyout, hresp;
    logic alarm, irq;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [7:0]  setIdx = 8'h00;
    logic [15:0] setVal = 16'h0000;
    logic [N_PHYS*VAL_W-1:0]   pA;
    logic [N_FLAG*VAL_W-1:0]   pF;
    logic [N_NETIN*VAL_W-1:0]  pN;
    logic [N_AOUT*VAL_W-1:0]   pO;
    logic [N_NETOUT*VAL_W-1:0] pQ;
    logic [N_BLK*VAL_W-1:0]    pB;
    int mismatches = 0, n_tests = 0;
    int srcs [12] = '{0, 7, 8, 71, 72, 103, 104, 111, 112, 127, 128, 143};
    logic [7:0]  satA [10] = '{A_GAIN, A_GAIN, A_OFFSET, A_OFFSET, A_UPPER,
                               A_UPPER, A_LOWER, A_LOWER, A_DEC, A_DEC};
    logic [31:0] satW [10] = '{32'h7D0, 32'hFFFFF830, 32'h4E20, 32'hFFFFB1E0,
        32'h7530, 32'hFFFFFFFB, 32'h4E21, 32'h4E20, 32'h7, 32'h2};
    logic [31:0] satE [10] = '{32'h3E8, 32'hFFFFFC18, 32'h2710, 32'hFFFFD8F0,
        32'h4E20, 32'h0, 32'h4E20, 32'h4E20, 32'h3, 32'h2};
    int wRaw [5] = '{510, 511, 490, 489, 500};
    logic wExp [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

    initial begin
        forever #10 clock = ~clock;
    end

    analog_window_watchdog u_analog_window_watchdog (
        .clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .armIn, .scanStrobe,
        .powerRestore, .physicalAnalogInput(pA), .analogFlag(pF),
        .networkAnalogInput(pN), .analogOutputValue(pO),
        .networkAnalogOutput(pQ), .blockResult(pB), .alarm, .irq);
    analog_sources_model u_analog_sources_model (
        .clock, .rst, .setEn, .setIdx, .setVal, .physicalAnalogInput(pA),
        .analogFlag(pF), .networkAnalogInput(pN), .analogOutputValue(pO),
        .networkAnalogOutput(pQ), .blockResult(pB));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= a; hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic setRaw(input logic [7:0] i, input int v);
        @(posedge clock); setEn <= 1'b1; setIdx <= i; setVal <= v[15:0];
        @(posedge clock); setEn <= 1'b0;
    endtask
    // alarm updates at the scan edge, so it is looked at just after it
    task automatic scan(input logic arm, input int raw, input logic expA);
        setRaw(8'h00, raw);
        @(posedge clock); armIn <= arm; scanStrobe <= 1'b1;
        @(posedge clock); scanStrobe <= 1'b0;
        #1 check({31'h0, alarm}, {31'h0, expA});
    endtask
    task automatic restore();
        @(posedge clock); powerRestore <= 1'b1;
        @(posedge clock); powerRestore <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        ahb(0, A_CTRL, 0); check(rd, 32'h0);
        ahb(0, A_STATUS, 0); check(rd, 32'h0);
        ahb(1, 32'h104, 32'h5); ahb(0, 32'h104, 0); check(rd, 32'h0);
        // an aliased high write would have landed in the gain register
        ahb(0, A_GAIN, 0); check(rd, 32'h0);
        ahb(0, 32'h40, 0); check(rd, 32'h0);
        for (int i = 0; i < 10; i++) begin
            ahb(1, satA[i], satW[i]);
            ahb(0, satA[i], 0);
            check(rd, satE[i]);
        end
        ahb(1, A_GAIN, 32'd100); ahb(1, A_OFFSET, 0); ahb(1, A_UPPER, 32'd10);
        ahb(1, A_LOWER, 32'd10); ahb(1, A_SRC, 0); ahb(1, A_INTMASK, 32'h7);
        scan(1, 500, 0);
        ahb(0, A_REF, 0); check(rd, 32'd500);
        ahb(0, A_INTSTAT, 0); check(rd, 32'h1);
        check({31'h0, irq}, 32'h1);
        ahb(1, A_INTSTAT, 32'h7); @(posedge clock);
        #1 check({31'h0, irq}, 32'h0);
        // decimals stay at 2 here; the window must not notice
        for (int i = 0; i < 5; i++) begin
            scan(1, wRaw[i], wExp[i]);
        end
        scan(1, 600, 1);
        ahb(1, A_INTMASK, 0); @(posedge clock);
        #1 check({31'h0, irq}, 32'h0);
        scan(0, 600, 0);
        ahb(1, A_MBLK, 32'h3); ahb(1, A_CTRL, 32'h2); setRaw(8'd131, 5);
        scan(1, 600, 0); scan(1, 605, 0); scan(1, 606, 1);
        ahb(1, A_CTRL, 0); ahb(1, A_GAIN, 32'hFFFFFF6A);
        ahb(1, A_OFFSET, 32'hFFFFFFE2); setRaw(8'h00, 7);
        ahb(0, A_SAMPLE, 0); check(rd, 32'hFFFFFFD8);
        ahb(1, A_GAIN, 32'd250); setRaw(8'h00, 500);
        ahb(0, A_SAMPLE, 0); check(rd, 32'd1220);
        ahb(1, A_GAIN, 32'd100); ahb(1, A_OFFSET, 0);
        foreach (srcs[i]) begin
            ahb(1, A_SRC, srcs[i]); setRaw(srcs[i][7:0], 1000 + srcs[i]);
            ahb(0, A_SAMPLE, 0); check(rd, 1000 + srcs[i]);
        end
        ahb(1, A_SRC, 32'd144); ahb(0, A_SAMPLE, 0);
        check(rd, 32'h0);
        ahb(1, A_SRC, 0);
        for (int r = 0; r < 2; r++) begin
            ahb(1, A_CTRL, r); scan(0, 500, 0); scan(1, 500, 0);
            ahb(0, A_STATUS, 0); check(rd, 32'h6);
            restore();
            ahb(0, A_STATUS, 0); check(rd, r ? 32'h6 : 32'h0);
        end
        print_verdict();
    end
endmodule
